/* sim/tshc_cfg_reg_chk.sv */
`timescale 1ns/100ps
module tshc_cfg_reg_chk
   import tshc_pkg::*;
(
   // Clock and reset
   input wire logic         mclk_in,
   input wire logic         rstn_in,
   // Register port
   input wire tshc_req_t    req_in,
   input wire logic [15:0]  rdata_out,
   // Samples and limits
   input wire logic         temp_valid_in,
   input wire logic signed [TEMP_W-1:0] temp_in,
   input wire tshc_limits_t limits_in,
   // Watched outputs
   input wire logic         over_upper_out,
   input wire logic         conv_run_out,
   input wire logic         crit_lock_out,
   input wire logic         win_lock_out,
   input wire tshc_cfg_t    cfg_out,
   input wire logic         alert_pin_oe_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   logic signed [13:0] thr;
   logic               wr1;
   logic               smp;
   logic               lock;
   // Falling trip point: margin is 12 steps doubled per code
   assign thr = limits_in.upper - ((cfg_out.hysteresis_select == 2'h0) ? 14'sh0000 :
                (14'sh000c <<< cfg_out.hysteresis_select));
   assign wr1 = req_in.wr && (req_in.ptr == 8'h01);
   assign smp = temp_valid_in && conv_run_out;
   assign lock = crit_lock_out || win_lock_out;

   AST_RSVD: assert property (rdata_out[15:11] == 5'h00 && cfg_out[15:11] == 5'h00)
      else $error("reserved bits set");
   AST_POL: assert property (cfg_out.alert_polarity == 1'b0 && rdata_out[1] == 1'b0)
      else $error("polarity bit changed");
   AST_HYS_WR: assert property (wr1 && !lock |=>
      cfg_out.hysteresis_select == $past(req_in.wdata[10:9])) else $error("select not taken");
   AST_LOCK: assert property (wr1 && lock |=> $stable(cfg_out[10:8]))
      else $error("locked field changed");
   AST_RD: assert property (req_in.rd && req_in.ptr == 8'h01 |=>
      rdata_out == ($past(cfg_out) & 16'hffdf)) else $error("read differs");
   AST_OFF: assert property (cfg_out.power_down_bit && $past(cfg_out.power_down_bit) |->
      !conv_run_out && !alert_pin_oe_out) else $error("shutdown not honoured");
   AST_RISE: assert property (smp && temp_in > limits_in.upper |=> ##1 over_upper_out)
      else $error("rise missed");
   AST_EARLY: assert property (smp && !$past(temp_valid_in) && !over_upper_out &&
      temp_in <= limits_in.upper |=> ##1 !over_upper_out) else $error("rise too early");
   AST_HOLD: assert property (smp && !$past(temp_valid_in) && over_upper_out &&
      temp_in >= thr |=> ##1 over_upper_out) else $error("flag dropped early");
   AST_CLR: assert property (smp && temp_in < thr |=> ##1 !over_upper_out)
      else $error("flag not cleared");
endmodule // tshc_cfg_reg_chk

bind tshc_cfg_reg tshc_cfg_reg_chk i_tshc_cfg_reg_chk (.mclk_in, .rstn_in, .req_in,
   .rdata_out, .temp_valid_in, .temp_in, .limits_in, .over_upper_out, .conv_run_out,
   .crit_lock_out, .win_lock_out, .cfg_out, .alert_pin_oe_out);

/* sim/tshc_cfg_reg_test.sv */
`timescale 1ns/100ps
module tshc_cfg_reg_test
   import tshc_pkg::*;
;
   localparam logic signed [TEMP_W-1:0] LIM = 13'sh0550;
   logic         mclk_in = 1'b0;
   logic         rstn_in = 1'b0;
   logic         temp_valid_in = 1'b0;
   logic signed [TEMP_W-1:0] temp_in = '0;
   tshc_limits_t limits_in = '{LIM, LIM, LIM};
   tshc_req_t    req;
   tshc_cfg_t    cfg;
   logic [15:0]  rdata;
   logic [15:0]  q;
   logic         up, lo, cr, run, clock_lk, win_lk, oe, pin;
   logic [31:0]  seed = 32'h0cad72f8;
   int           err_count = 0;
   int           total_checks = 0;

   tshc_cfg_reg i_tshc_cfg_reg (.mclk_in, .rstn_in, .req_in(req), .rdata_out(rdata),
      .temp_valid_in, .temp_in, .limits_in, .over_upper_out(up), .below_lower_out(lo),
      .over_crit_out(cr), .conv_run_out(run), .crit_lock_out(clock_lk),
      .win_lock_out(win_lk), .cfg_out(cfg), .alert_pin_out(pin), .alert_pin_oe_out(oe));
   tshc_host_model i_tshc_host_model (.mclk_in, .rdata_in(rdata), .req_out(req));

   initial forever #2.5 mclk_in = ~mclk_in;

   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic signed [TEMP_W-1:0] margin(input logic [1:0] c);
      return (c == 2'h0) ? 13'sh0000 : (13'sh000c <<< c);
   endfunction
   task automatic wr(input logic [15:0] d);
      i_tshc_host_model.access(1'b1, 8'h01, d, q);
   endtask
   task automatic rd(input logic [7:0] p, input logic [15:0] exp);
      i_tshc_host_model.access(1'b0, p, 16'h0000, q);
      check("config read", exp, q);
   endtask
   // Flags land two edges after the sample is taken
   task automatic samp(input logic signed [TEMP_W-1:0] t, input logic [3:0] e);
      @(posedge mclk_in);
      temp_valid_in <= 1'b1;
      temp_in <= t;
      @(posedge mclk_in);
      temp_valid_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      #1;
      check("pin lower crit upper", {12'h000, e}, {11'h000, pin, oe, lo, cr, up});
   endtask

   initial begin
      repeat (19) @(posedge mclk_in);
      #1;
      check("reset image", 16'h0000, cfg);
      @(posedge mclk_in);
      rstn_in <= 1'b1;
      rd(8'h01, 16'h0010);
      rd(8'h02, 16'h0000);
      $display("reset test done");
      // All three limits equal, alert on critical only
      for (int c = 0; c < 4; c++) begin
         wr({5'h00, c[1:0], 9'h00c});
         rd(8'h01, {5'h00, c[1:0], 9'h00c});
         samp(LIM, 4'h4);
         samp(LIM + 13'sh0001, 4'hb);
         samp(LIM - margin(c[1:0]), 4'hb);
         samp(LIM - margin(c[1:0]) - 13'sh0001, 4'h4);
      end
      $display("hysteresis test done");
      samp(LIM + 13'sh0001, 4'hb);
      wr(16'h010c);
      @(posedge mclk_in);
      #1;
      check("run and pin", 16'h0000, {14'h0000, run, oe});
      samp(13'sh0000, 4'h3);
      wr(16'h000c);
      samp(13'sh0000, 4'h4);
      check("run", 16'h0001, {15'h0000, run});
      $display("shutdown test done");
      // Interrupt mode: alert latches on the crossing and holds until released
      wr(16'h000d);
      samp(LIM + 13'sh0001, 4'hb);
      samp(13'sh0000, 4'hc);
      wr(16'h002d);
      samp(13'sh0000, 4'h4);
      rd(8'h01, 16'h000d);
      $display("interrupt test done");
      // Locks kept clear so every write lands
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         wr((seed[15:0] & 16'hff3f) | 16'h0004);
         rd(8'h01, (seed[15:0] & 16'h070d) | 16'h0004);
      end
      $display("random write test done");
      for (int b = 6; b < 8; b++) begin
         @(posedge mclk_in);
         rstn_in <= 1'b0;
         repeat (20) @(posedge mclk_in);
         rstn_in <= 1'b1;
         wr(16'h0200 | (16'h0001 << b));
         wr(16'h0700);
         rd(8'h01, 16'h0210 | (16'h0001 << b));
         check("locks", {14'h0000, b == 7, b == 6}, {14'h0000, clock_lk, win_lk});
      end
      $display("lock test done");
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge mclk_in);
      err_count++;
      report_and_stop();
   end
endmodule // tshc_cfg_reg_test

/* sim/tshc_host_model.sv */
`timescale 1ns/100ps
module tshc_host_model
   import tshc_pkg::*;
(
   // Clock
   input  wire logic        mclk_in,
   // Register port
   input  wire logic [15:0] rdata_in,
   output tshc_req_t        req_out
);
   initial req_out = '0;
   // Idle edge after each request keeps one driver per time step
   task automatic access(input logic w, input logic [7:0] p, input logic [15:0] d,
                         output logic [15:0] q);
      @(posedge mclk_in);
      req_out <= '{ptr: p, wr: w, rd: !w, wdata: d};
      @(posedge mclk_in);
      req_out <= '0;
      #1;
      q = rdata_in;
   endtask
endmodule // tshc_host_model

/* verilog/tshc_cfg_reg.sv */
`timescale 1ns/100ps
// Behaviour
// - Sixteen-bit configuration register at pointer 01h, readable and writable by host.
// - Bits 15 to 11 reserved, read-only, always read zero.
// - Bits 10:9 choose hysteresis: off, 1.5, 3.0 or 6.0 degC.
// - Hysteresis select resets to 00, no hysteresis until programmed.
// - Selected hysteresis applies to upper, lower and critical limits alike.
// - Hysteresis only on falling temperature; rising crossings use the bare limit.
// - Comparator alert on upper or critical limit holds until temperature below threshold minus hysteresis.
// - Low byte holds locks, release, status, enable, crit-only, polarity, mode; reset zero.
// - Over-upper flag stays set until below upper limit minus hysteresis.
// - Hysteresis and shutdown writes ignored while either lock bit is set.
// - Shutdown bit stops conversions and releases alert pin; zero keeps running.
module tshc_cfg_reg
   import tshc_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk_in,
   input  wire logic                     rstn_in,
   // Register access from the serial front end
   input  wire tshc_req_t                req_in,
   output logic [15:0]                   rdata_out,
   // Conversion results and trip limits
   input  wire logic                     temp_valid_in,
   input  wire logic signed [TEMP_W-1:0] temp_in,
   input  wire tshc_limits_t             limits_in,
   // Status and control outward
   output logic                          over_upper_out,
   output logic                          below_lower_out,
   output logic                          over_crit_out,
   output logic                          conv_run_out,
   output logic                          crit_lock_out,
   output logic                          win_lock_out,
   output tshc_cfg_t                     cfg_out,
   // Alert pin, open drain
   output logic                          alert_pin_out,
   output logic                          alert_pin_oe_out
);

   tshc_cfg_t         cfg;
   tshc_cfg_t         next_cfg;
   logic              cond_q;
   logic              next_cond_q;
   logic              latched;
   logic              next_latched;
   logic [15:0]       next_rdata;
   logic              next_over_upper;
   logic              next_below_lower;
   logic              next_over_crit;
   logic              next_alert_oe;
   logic              next_conv_run;
   logic              cfg_wr;
   logic              locked;
   logic              cond;
   logic              active;
   logic              sample;
   logic [LIM_N-1:0]  above;
   logic [TEMP_W-1:0] margin;
   logic signed [TEMP_W-1:0] limit_v [LIM_N];

   // ---------------------------------------------------------------
   // Limit comparators
   // ---------------------------------------------------------------
   // Frozen in shutdown so the alert returns to its old state on exit
   // no conversions
   assign sample = temp_valid_in && !cfg.power_down_bit;
   assign margin = tshc_margin(cfg.hysteresis_select);
   assign limit_v[LIM_UPPER] = limits_in.upper;
   assign limit_v[LIM_LOWER] = limits_in.lower;
   assign limit_v[LIM_CRIT]  = limits_in.crit;

   genvar gi;
   generate
      for (gi = 0; gi < LIM_N; gi++) begin : g_lim
         tshc_limit_cmp u_cmp (
            .mclk_in   (mclk_in),
            .rstn_in   (rstn_in),
            .sample_in (sample),
            .temp_in   (temp_in),
            .limit_in  (limit_v[gi]),
            .margin_in (margin),
            .above_out (above[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   assign cfg_wr = req_in.wr && (req_in.ptr == CFG_PTR);
   assign locked = cfg.critical_limit_lock || cfg.alarm_window_lock;

   always_comb begin
      next_cfg = cfg;
      next_cfg.reserved_bits   = RSVD_RESET;
      next_cfg.alert_polarity  = 1'b0;
      next_cfg.alert_release   = 1'b0;
      next_cfg.alert_status_flag = active;
      if (cfg_wr) begin
         // Lock state before the write decides, so a locking write still lands
         // locked fields
         if (!locked) begin
            next_cfg.hysteresis_select = req_in.wdata[HYS_MSB:HYS_LSB];
            next_cfg.power_down_bit    = req_in.wdata[PWRDN_BIT];
         end
         // Locks are sticky until power-on reset
         next_cfg.critical_limit_lock = cfg.critical_limit_lock
                                        | req_in.wdata[CRIT_LOCK_BIT];
         next_cfg.alarm_window_lock   = cfg.alarm_window_lock
                                        | req_in.wdata[WIN_LOCK_BIT];
         next_cfg.alert_release       = req_in.wdata[RELEASE_BIT];
         next_cfg.alert_output_enable = req_in.wdata[OUT_EN_BIT];
         next_cfg.critical_only_alert = req_in.wdata[CRIT_ONLY_BIT];
         next_cfg.alert_mode_select   = req_in.wdata[MODE_BIT];
      end
      next_conv_run = !next_cfg.power_down_bit;
   end

   // ---------------------------------------------------------------
   // Alert logic
   // ---------------------------------------------------------------
   always_comb begin
      if (cfg.critical_only_alert) begin
         cond = above[LIM_CRIT];
      end else begin
         cond = above[LIM_UPPER] || !above[LIM_LOWER] || above[LIM_CRIT];
      end
      // Status and pin follow the latch in interrupt mode, the level otherwise
      active = cfg.alert_mode_select ? latched : cond;
      next_cond_q = cond;
      next_latched = 1'b0;
      if (cfg.alert_mode_select) begin
         // New crossing wins over a release in the same cycle
         next_latched = (latched && !(cfg_wr && req_in.wdata[RELEASE_BIT]))
                        || (cond && !cond_q);
      end
      next_alert_oe    = cfg.alert_output_enable && !cfg.power_down_bit && active;
      next_over_upper  = above[LIM_UPPER];
      next_below_lower = !above[LIM_LOWER];
      next_over_crit   = above[LIM_CRIT];
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = rdata_out;
      if (req_in.rd) begin
         // Registers outside this block answer elsewhere; here they read zero
         next_rdata = 16'h0000;
         if (req_in.ptr == CFG_PTR) begin
            next_rdata = cfg;
            next_rdata[RSVD_MSB:RSVD_LSB] = RSVD_RESET;
            next_rdata[RELEASE_BIT] = 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration state registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg           <= CFG_RESET;
         conv_run_out  <= 1'b1;
         crit_lock_out <= 1'b0;
         win_lock_out  <= 1'b0;
         cfg_out       <= CFG_RESET;
      end else begin
         cfg           <= next_cfg;
         conv_run_out  <= next_conv_run;
         crit_lock_out <= next_cfg.critical_limit_lock;
         win_lock_out  <= next_cfg.alarm_window_lock;
         cfg_out       <= next_cfg;
      end
   end

   // ---------------------------------------------------------------
   // Alert state registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cond_q           <= 1'b0;
         latched          <= 1'b0;
         over_upper_out   <= 1'b0;
         below_lower_out  <= 1'b0;
         over_crit_out    <= 1'b0;
         alert_pin_out    <= 1'b0;
         alert_pin_oe_out <= 1'b0;
      end else begin
         cond_q           <= next_cond_q;
         latched          <= next_latched;
         over_upper_out   <= next_over_upper;
         below_lower_out  <= next_below_lower;
         over_crit_out    <= next_over_crit;
         // Active-low polarity only: the pin is pulled low when asserted
         alert_pin_out    <= 1'b0;
         alert_pin_oe_out <= next_alert_oe;
      end
   end

   // ---------------------------------------------------------------
   // Read data register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 16'h0000;
      end else begin
         rdata_out <= next_rdata;
      end
   end

endmodule // tshc_cfg_reg

/* verilog/tshc_limit_cmp.sv */
`timescale 1ns/100ps
module tshc_limit_cmp
   import tshc_pkg::*;
(
   // Clock and reset
   input  wire logic                     mclk_in,
   input  wire logic                     rstn_in,
   // Sample
   input  wire logic                     sample_in,
   input  wire logic signed [TEMP_W-1:0] temp_in,
   input  wire logic signed [TEMP_W-1:0] limit_in,
   input  wire logic        [TEMP_W-1:0] margin_in,
   // State
   output logic                          above_out
);

   logic signed [TEMP_W:0] temp_x;
   logic signed [TEMP_W:0] limit_x;
   logic signed [TEMP_W:0] floor_x;
   logic                   next_above;

   // ---------------------------------------------------------------
   // Falling-only hysteresis
   // ---------------------------------------------------------------
   // Widened by one bit so limit minus margin never wraps
   always_comb begin
      temp_x  = {temp_in[TEMP_W-1], temp_in};
      limit_x = {limit_in[TEMP_W-1], limit_in};
      floor_x = limit_x - $signed({1'b0, margin_in});
      next_above = above_out;
      if (sample_in) begin
         if (!above_out) begin
            next_above = temp_x > limit_x;
         end else begin
            next_above = !(temp_x < floor_x);
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         above_out <= 1'b0;
      end else begin
         above_out <= next_above;
      end
   end

endmodule // tshc_limit_cmp

/* verilog/tshc_pkg.sv */
package tshc_pkg;

   // ---------------------------------------------------------------
   // Register access
   // ---------------------------------------------------------------
   localparam logic [7:0]  CFG_PTR        = 8'h01;
   localparam logic [15:0] CFG_RESET      = 16'h0000;
   localparam logic [4:0]  RSVD_RESET     = 5'h00;
   localparam logic [1:0]  HYS_RESET      = 2'h0;

   // Field positions inside the configuration word
   localparam int RSVD_MSB      = 15;
   localparam int RSVD_LSB      = 11;
   localparam int HYS_MSB       = 10;
   localparam int HYS_LSB       = 9;
   localparam int PWRDN_BIT     = 8;
   localparam int CRIT_LOCK_BIT = 7;
   localparam int WIN_LOCK_BIT  = 6;
   localparam int RELEASE_BIT   = 5;
   localparam int STATUS_BIT    = 4;
   localparam int OUT_EN_BIT    = 3;
   localparam int CRIT_ONLY_BIT = 2;
   localparam int POL_BIT       = 1;
   localparam int MODE_BIT      = 0;

   // ---------------------------------------------------------------
   // Temperature format: signed, 0.0625 degC per step
   // ---------------------------------------------------------------
   localparam int TEMP_W = 13;
   localparam logic [TEMP_W-1:0] MARGIN_OFF = 13'h0000;
   localparam logic [TEMP_W-1:0] MARGIN_1P5 = 13'h0018;
   localparam logic [TEMP_W-1:0] MARGIN_3P0 = 13'h0030;
   localparam logic [TEMP_W-1:0] MARGIN_6P0 = 13'h0060;

   // Limit order in the comparator array
   localparam int LIM_UPPER = 0;
   localparam int LIM_LOWER = 1;
   localparam int LIM_CRIT  = 2;
   localparam int LIM_N     = 3;

   typedef enum logic [1:0] {
      TSHC_HYS_OFF,
      TSHC_HYS_1P5,
      TSHC_HYS_3P0,
      TSHC_HYS_6P0
   } tshc_hys_t;

   typedef struct packed {
      logic [4:0] reserved_bits;
      logic [1:0] hysteresis_select;
      logic       power_down_bit;
      logic       critical_limit_lock;
      logic       alarm_window_lock;
      logic       alert_release;
      logic       alert_status_flag;
      logic       alert_output_enable;
      logic       critical_only_alert;
      logic       alert_polarity;
      logic       alert_mode_select;
   } tshc_cfg_t;

   typedef struct packed {
      logic [7:0]  ptr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } tshc_req_t;

   typedef struct packed {
      logic signed [TEMP_W-1:0] upper;
      logic signed [TEMP_W-1:0] lower;
      logic signed [TEMP_W-1:0] crit;
   } tshc_limits_t;

   function automatic logic [TEMP_W-1:0] tshc_margin(input logic [1:0] sel);
      logic [TEMP_W-1:0] m;
      m = MARGIN_OFF;
      case (sel)
         TSHC_HYS_1P5: m = MARGIN_1P5;
         TSHC_HYS_3P0: m = MARGIN_3P0;
         TSHC_HYS_6P0: m = MARGIN_6P0;
         default:      m = MARGIN_OFF;
      endcase
      return m;
   endfunction

endpackage
